// ==== rtl/sat_pkg.sv ====
package sat_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFS_SECNUM = 8'h00;
   localparam logic [7:0] OFS_CYLLO = 8'h04;
   localparam logic [7:0] OFS_CYLHI = 8'h08;
   localparam logic [7:0] OFS_DEVHEAD = 8'h0c;
   localparam logic [7:0] OFS_SECCNT = 8'h10;
   localparam logic [7:0] OFS_CMD = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_ERROR = 8'h1c;
   localparam logic [7:0] OFS_RESULT = 8'h20;
   localparam logic [7:0] OFS_DEFCYL = 8'h24;
   localparam logic [7:0] OFS_DEFHEADS = 8'h28;
   localparam logic [7:0] OFS_DEFSPT = 8'h2c;
   localparam logic [7:0] OFS_CURCYL = 8'h30;
   localparam logic [7:0] OFS_CURHEADS = 8'h34;
   localparam logic [7:0] OFS_CURSPT = 8'h38;
   localparam logic [7:0] OFS_CURCAP = 8'h3c;
   localparam logic [7:0] OFS_TOTAL = 8'h40;
   // command codes
   localparam logic [7:0] CMD_ACCESS = 8'h01;
   localparam logic [7:0] CMD_INIT = 8'h02;
   localparam logic [7:0] CMD_SETMAX = 8'h03;
   // field positions
   localparam int DH_LBA_BIT = 6;
   localparam int ST_ERR_BIT = 0;
   localparam int ST_MODE_BIT = 1;
   localparam int ST_READY_BIT = 6;
   localparam int ST_BUSY_BIT = 7;
   localparam int ER_ABORT_BIT = 2;
   localparam int ER_NOTFOUND_BIT = 4;
   // geometry limits and defaults (16,514,064 and 268,435,456 sectors)
   localparam logic [23:0] GEOM_MAX = 24'hfbfc10;
   localparam logic [28:0] TOTAL_LIMIT = 29'h1000_0000;
   localparam logic [28:0] NATIVE_TOTAL = 29'h0fbfc10;
   localparam logic [15:0] DEF_CYL = 16'h3fff;
   localparam logic [15:0] CYL_CAP = 16'hffff;
   localparam logic [4:0] DEF_HEADS = 5'h10;
   localparam logic [7:0] DEF_SPT = 8'h3f;
   localparam logic CHS_SUPPORTED = 1'b1;
   localparam logic [4:0] DIV_STEPS = 5'h18;

   typedef struct packed {
      logic [15:0] cyl;
      logic [4:0] heads;
      logic [7:0] spt;
   } geom_s;

   typedef enum logic [1:0] {
      CTL_IDLE = 2'b01,
      CTL_DIV = 2'b10
   } ctl_e;
endpackage : sat_pkg

// ==== rtl/block_mapper.sv ====
// combinational cylinder/head/sector to linear block number
module block_mapper (
   input wire logic [15:0] cyl,
   input wire logic [3:0] head,
   input wire logic [7:0] sector,
   input wire sat_pkg::geom_s geom,
   output logic [28:0] block
);
   logic [28:0] track;

   // evaluated at 29 bits: 16 + 5 + 8 cannot overflow
   assign track = 29'(cyl) * 29'(geom.heads) + 29'(head);
   assign block = track * 29'(geom.spt) + 29'(sector) - 29'h1; // [RL9]
endmodule : block_mapper

// ==== rtl/cyl_divider.sv ====
// restoring divider, one quotient bit per cycle
module cyl_divider (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [23:0] dividend,
   input wire logic [11:0] divisor,
   output logic done,
   output logic [23:0] quotient
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [4:0] cnt;
      logic [23:0] quo;
      logic [12:0] rem;
   } div_s;

   div_s r;
   div_s n;
   logic [12:0] shifted;

   always_comb begin
      n = r;
      n.done = 1'b0;
      shifted = {r.rem[11:0], r.quo[23]};
      if (start) begin
         n.busy = 1'b1;
         n.cnt = sat_pkg::DIV_STEPS;
         n.quo = dividend;
         n.rem = 13'h0;
      end else if (r.busy) begin
         if (shifted >= {1'b0, divisor}) begin
            n.rem = shifted - {1'b0, divisor};
            n.quo = {r.quo[22:0], 1'b1};
         end else begin
            n.rem = shifted;
            n.quo = {r.quo[22:0], 1'b0};
         end
         n.cnt = r.cnt - 5'h1;
         if (r.cnt == 5'h1) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done = r.done;
   assign quotient = r.quo;
endmodule : cyl_divider

// ==== rtl/sector_address_translation_check.sv ====
// Notes on behaviour
// RL1: block addressing always available
// RL2: geometry addressing present for small capacities
// RL3: large capacity geometry support optional
// RL4: reset restores default geometry translation
// RL5: sector 1..255, head 0..15, cylinder 0..65535
// RL6: parameter init computes logical cylinder count
// RL7: status reports command's own addressing method
// RL8: addressing bit selects method per command
// RL9: linear map, block 0 is c0 h0 s1
// RL10: default cylinders 1..65535 or 16383
// RL11: default heads 1..16
// RL12: default sectors 1..63, product bounded
// RL13: current cylinders, heads reload from defaults
// RL14: current sectors 1..255, reload from default
// RL15: current capacity is product, bounded
// RL16: geometry words zero when unsupported
// RL17: total sectors between 1 and 268435456
// RL18: init and max-address commands alter geometry
// RL19: generous geometry address acceptance optional
// RL20: geometry out of range sets errors
// RL21: block number out of range sets errors
// RL22: block number assembled from address registers
module sector_address_translation_check (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   typedef struct packed {
      sat_pkg::ctl_e st;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic [7:0] sec_num;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] dev_head;
      logic [7:0] sec_cnt;
      logic err;
      logic mode_lba;
      logic not_found;
      logic aborted;
      logic [28:0] result;
      logic [15:0] def_cyl;
      sat_pkg::geom_s cur;
      logic [28:0] total;
      logic [4:0] pend_heads;
      logic [7:0] pend_spt;
      logic div_start;
   } core_s;

   // defaults are restored by the asynchronous reset only
   localparam core_s CORE_RST = '{
      st: sat_pkg::CTL_IDLE,
      dp_valid: 1'b0,
      dp_write: 1'b0,
      dp_addr: 8'h00,
      hready: 1'b1,
      hresp: 1'b0,
      hrdata: 32'h0,
      sec_num: 8'h00,
      cyl_lo: 8'h00,
      cyl_hi: 8'h00,
      dev_head: 8'h00,
      sec_cnt: 8'h00,
      err: 1'b0,
      mode_lba: 1'b0,
      not_found: 1'b0,
      aborted: 1'b0,
      result: 29'h0,
      def_cyl: sat_pkg::DEF_CYL,
      cur: '{cyl: sat_pkg::DEF_CYL, heads: sat_pkg::DEF_HEADS, spt: sat_pkg::DEF_SPT},
      total: sat_pkg::NATIVE_TOTAL,
      pend_heads: 5'h0,
      pend_spt: 8'h0,
      div_start: 1'b0
   };

   core_s r;
   core_s n;

   logic accept;
   logic cmd_wr;
   logic [7:0] opcode;
   logic [27:0] logical_block_addressing;
   logic [15:0] cyl;
   logic [3:0] head;
   logic [28:0] map_block;
   logic lba_bad;
   logic chs_bad;
   logic geom_ok;
   logic [28:0] cur_cap;
   logic [28:0] max_req;
   logic [23:0] div_num;
   logic div_done;
   logic [23:0] div_quo;
   logic [4:0] init_heads;

   assign logical_block_addressing = {r.dev_head[3:0], r.cyl_hi, r.cyl_lo, r.sec_num}; // [RL22]
   assign cyl = {r.cyl_hi, r.cyl_lo};
   assign head = r.dev_head[3:0];
   assign cur_cap = r.cur.cyl * r.cur.heads * r.cur.spt; // [RL15]
   assign max_req = {1'b0, logical_block_addressing} + 29'h1;
   assign init_heads = {1'b0, head} + 5'h1;
   assign div_num = ({1'b0, r.total} > {6'h0, sat_pkg::GEOM_MAX}) ?
      sat_pkg::GEOM_MAX : r.total[23:0];
   // geometry words read as zero without support or with a zero default
   assign geom_ok = sat_pkg::CHS_SUPPORTED && (r.def_cyl != 16'h0) &&
      (sat_pkg::DEF_HEADS != 5'h0) && (sat_pkg::DEF_SPT != 8'h0); // [RL16] [RL2] [RL3]

   assign lba_bad = ({1'b0, logical_block_addressing} >= r.total); // [RL21]
   assign chs_bad = !geom_ok || (cyl >= r.cur.cyl) ||
      ({1'b0, head} >= r.cur.heads) || (r.sec_num == 8'h0) ||
      (r.sec_num > r.cur.spt); // [RL20] [RL5] [RL19]

   block_mapper u_map (
      .cyl(cyl),
      .head(head),
      .sector(r.sec_num),
      .geom(r.cur),
      .block(map_block)
   );

   cyl_divider u_div (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .start(r.div_start),
      .dividend(div_num),
      .divisor(12'(r.pend_heads * r.pend_spt)),
      .done(div_done),
      .quotient(div_quo)
   );

   assign accept = hsel && htrans[1] && hready;
   assign cmd_wr = r.dp_valid && r.dp_write && (r.dp_addr == sat_pkg::OFS_CMD) &&
      (r.st == sat_pkg::CTL_IDLE);
   assign opcode = hwdata[7:0];

   always_comb begin
      n = r;
      n.div_start = 1'b0;
      n.dp_valid = accept;
      if (accept) begin
         n.dp_write = hwrite;
         n.dp_addr = haddr[7:0];
         // reads take one wait state so the read data comes from a flop
         if (!hwrite) begin
            n.hready = 1'b0;
         end
      end
      if (r.dp_valid && !r.dp_write) begin
         n.hready = 1'b1;
         n.hrdata = 32'h0;
         case (r.dp_addr)
            sat_pkg::OFS_SECNUM: n.hrdata[7:0] = r.sec_num;
            sat_pkg::OFS_CYLLO: n.hrdata[7:0] = r.cyl_lo;
            sat_pkg::OFS_CYLHI: n.hrdata[7:0] = r.cyl_hi;
            sat_pkg::OFS_DEVHEAD: n.hrdata[7:0] = r.dev_head;
            sat_pkg::OFS_SECCNT: n.hrdata[7:0] = r.sec_cnt;
            sat_pkg::OFS_STATUS: begin
               n.hrdata[sat_pkg::ST_ERR_BIT] = r.err;
               n.hrdata[sat_pkg::ST_MODE_BIT] = r.mode_lba; // [RL7]
               n.hrdata[sat_pkg::ST_READY_BIT] = 1'b1;
               n.hrdata[sat_pkg::ST_BUSY_BIT] = (r.st == sat_pkg::CTL_DIV);
            end
            sat_pkg::OFS_ERROR: begin
               n.hrdata[sat_pkg::ER_ABORT_BIT] = r.aborted;
               n.hrdata[sat_pkg::ER_NOTFOUND_BIT] = r.not_found;
            end
            sat_pkg::OFS_RESULT: n.hrdata[28:0] = r.result;
            sat_pkg::OFS_DEFCYL: n.hrdata[15:0] = geom_ok ? r.def_cyl : 16'h0;
            sat_pkg::OFS_DEFHEADS: n.hrdata[4:0] = geom_ok ? sat_pkg::DEF_HEADS : 5'h0;
            sat_pkg::OFS_DEFSPT: n.hrdata[7:0] = geom_ok ? sat_pkg::DEF_SPT : 8'h0;
            sat_pkg::OFS_CURCYL: n.hrdata[15:0] = geom_ok ? r.cur.cyl : 16'h0;
            sat_pkg::OFS_CURHEADS: n.hrdata[4:0] = geom_ok ? r.cur.heads : 5'h0;
            sat_pkg::OFS_CURSPT: n.hrdata[7:0] = geom_ok ? r.cur.spt : 8'h0;
            sat_pkg::OFS_CURCAP: n.hrdata[28:0] = geom_ok ? cur_cap : 29'h0;
            sat_pkg::OFS_TOTAL: n.hrdata[28:0] = r.total; // [RL17]
            default: n.hrdata = 32'h0;
         endcase
      end
      if (r.dp_valid && r.dp_write) begin
         case (r.dp_addr)
            sat_pkg::OFS_SECNUM: n.sec_num = hwdata[7:0];
            sat_pkg::OFS_CYLLO: n.cyl_lo = hwdata[7:0];
            sat_pkg::OFS_CYLHI: n.cyl_hi = hwdata[7:0];
            sat_pkg::OFS_DEVHEAD: n.dev_head = hwdata[7:0];
            sat_pkg::OFS_SECCNT: n.sec_cnt = hwdata[7:0];
            default: n.sec_num = r.sec_num;
         endcase
      end
      if (cmd_wr) begin
         n.err = 1'b0;
         n.not_found = 1'b0;
         n.aborted = 1'b0;
         case (opcode)
            sat_pkg::CMD_ACCESS: begin
               // the method used is the one the command asked for
               n.mode_lba = r.dev_head[sat_pkg::DH_LBA_BIT]; // [RL8] [RL7]
               if (r.dev_head[sat_pkg::DH_LBA_BIT]) begin
                  n.err = lba_bad; // [RL1] [RL21]
                  n.not_found = lba_bad;
                  if (!lba_bad) begin
                     n.result = {1'b0, logical_block_addressing};
                  end
               end else begin
                  n.err = chs_bad; // [RL20]
                  n.not_found = chs_bad;
                  if (!chs_bad) begin
                     n.result = map_block; // [RL9]
                  end
               end
            end
            sat_pkg::CMD_INIT: begin
               if (!geom_ok || r.sec_cnt == 8'h0) begin
                  n.err = 1'b1;
                  n.aborted = 1'b1;
               end else begin
                  n.pend_heads = init_heads; // [RL6]
                  n.pend_spt = r.sec_cnt;
                  n.div_start = 1'b1;
                  n.st = sat_pkg::CTL_DIV;
               end
            end
            sat_pkg::CMD_SETMAX: begin
               // a new limit may not cut below the current geometry capacity
               if (max_req > sat_pkg::NATIVE_TOTAL || max_req < cur_cap) begin
                  n.err = 1'b1;
                  n.aborted = 1'b1;
               end else begin
                  n.total = max_req; // [RL18]
               end
            end
            default: begin
               n.err = 1'b1;
               n.aborted = 1'b1;
            end
         endcase
      end
      case (r.st)
         sat_pkg::CTL_IDLE: n.st = n.st;
         sat_pkg::CTL_DIV: begin
            if (div_done) begin
               n.st = sat_pkg::CTL_IDLE;
               if (div_quo == 24'h0) begin
                  n.err = 1'b1;
                  n.aborted = 1'b1;
               end else begin
                  // cylinders cap at 65535; the product stays under the bound
                  n.cur.cyl = (div_quo > {8'h0, sat_pkg::CYL_CAP}) ?
                     sat_pkg::CYL_CAP : div_quo[15:0]; // [RL6] [RL15]
                  n.cur.heads = r.pend_heads; // [RL18]
                  n.cur.spt = r.pend_spt;
               end
            end
         end
         default: n.st = sat_pkg::CTL_IDLE;
      endcase
   end

   // reset loads the default translation into the current words
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r <= CORE_RST; // [RL4] [RL13] [RL14] [RL10] [RL11] [RL12]
      end else begin
         r <= n;
      end
   end

   assign hreadyout = r.hready;
   assign hresp = r.hresp;
   assign hrdata = r.hrdata;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   logic acc;
   logic init_go;
   assign acc = cmd_wr && (opcode == sat_pkg::CMD_ACCESS);
   assign init_go = cmd_wr && (opcode == sat_pkg::CMD_INIT) && geom_ok &&
      (r.sec_cnt != 8'h0);

   sequence s_init_go;
      init_go ##1 (r.st == sat_pkg::CTL_DIV);
   endsequence
   sequence s_div_end;
      (r.st == sat_pkg::CTL_DIV) [*8] ##[17:25] (r.st == sat_pkg::CTL_IDLE);
   endsequence
   property p_init_runs;
      s_init_go |-> s_div_end;
   endproperty

   a_lba_bound_err: assert property ( // [RL21]
      acc && r.dev_head[sat_pkg::DH_LBA_BIT] && lba_bad |=> r.err && r.not_found)
      else $error("block number at or above total not flagged");
   a_geom_bound_err: assert property ( // [RL20]
      acc && !r.dev_head[sat_pkg::DH_LBA_BIT] && chs_bad |=> r.err && r.not_found)
      else $error("geometry address out of range not flagged");
   a_lba_clean_pass: assert property ( // [RL22]
      acc && r.dev_head[sat_pkg::DH_LBA_BIT] && !lba_bad
      |=> !r.err && r.result == {1'b0, $past(logical_block_addressing)})
      else $error("valid block address rejected or misassembled");
   a_mode_echo: assert property ( // [RL7]
      acc |=> r.mode_lba == $past(r.dev_head[sat_pkg::DH_LBA_BIT]))
      else $error("reported addressing method differs from command");
   a_first_block: assert property ( // [RL9]
      acc && !r.dev_head[sat_pkg::DH_LBA_BIT] && !chs_bad && cyl == 16'h0 &&
      head == 4'h0 && r.sec_num == 8'h1 |=> r.result == 29'h0)
      else $error("cylinder 0 head 0 sector 1 is not block 0");
   a_init_divide: assert property (p_init_runs) // [RL6]
      else $error("parameter init did not finish in time");
   a_cap_bound: assert property ( // [RL15]
      cur_cap <= {5'h0, sat_pkg::GEOM_MAX} && cur_cap <= r.total)
      else $error("current capacity exceeds its bounds");
   a_total_range: assert property ( // [RL17]
      r.total != 29'h0 && r.total <= sat_pkg::TOTAL_LIMIT)
      else $error("total sector count out of range");
   a_cur_range: assert property ( // [RL13]
      r.cur.heads != 5'h0 && r.cur.heads <= sat_pkg::DEF_HEADS &&
      r.cur.spt != 8'h0 && r.cur.cyl != 16'h0)
      else $error("current geometry word out of range");
   a_init_abort: assert property ( // [RL6]
      cmd_wr && opcode == sat_pkg::CMD_INIT && r.sec_cnt == 8'h0 |=> r.err && r.aborted)
      else $error("parameter init with zero sectors not aborted");
   a_setmax_floor: assert property ( // [RL15]
      cmd_wr && opcode == sat_pkg::CMD_SETMAX && max_req < cur_cap
      |=> r.aborted && r.total == $past(r.total))
      else $error("limit below current capacity was taken");
   a_setmax_apply: assert property ( // [RL18]
      cmd_wr && opcode == sat_pkg::CMD_SETMAX && max_req <= sat_pkg::NATIVE_TOTAL &&
      max_req >= cur_cap |=> !r.err && r.total == $past(max_req))
      else $error("valid new limit not applied");
endmodule : sector_address_translation_check

// ==== verification/host_adapter_model.sv ====
// single-transfer bus master standing in for the host adapter
module host_adapter_model (
   input wire logic clk_sys,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int to_cnt = 0;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
   end
   // a hang is counted here and judged by the bench
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) to_cnt++;
   endtask : wait_ready
   // sector number, cylinder low, cylinder high, device/head and command words each go as one word
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      // released address lines flip so stale values are never trusted
      haddr <= ~haddr;
      if (wr) hwdata <= wd;
      wait_ready();
      rd = hrdata;
      if (wr) hwdata <= ~wd;
   endtask : xfer
endmodule : host_adapter_model

// ==== verification/test_sector_address_translation_check.sv ====
module test_sector_address_translation_check;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] nf = 32'h1 << sat_pkg::ER_NOTFOUND_BIT;
   localparam logic [31:0] ab = 32'h1 << sat_pkg::ER_ABORT_BIT;
   localparam logic [31:0] lb = 32'h1 << sat_pkg::DH_LBA_BIT;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, cc, ch, cs, tot;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] seed = 32'hf3921c23;
   int error_cnt = 0;
   int check_count = 0;

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   host_adapter_model host_adapter_model_i (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hreadyout(hreadyout), .hrdata(hrdata));

   sector_address_translation_check sector_address_translation_check_i (.clk_sys(clk_sys),
      .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      host_adapter_model_i.xfer(wr, a, wd, rd);
      chk("hresp", 32'h0, 32'(hresp));
      if (host_adapter_model_i.to_cnt != 0) begin
         error_cnt++;
         summarize();
      end
   endtask : acc

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      acc(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask : rchk

   task automatic cmd(input logic [7:0] op, input logic [31:0] s, c, dh, sc);
      acc(1'b1, sat_pkg::OFS_SECNUM, s & 32'hff);
      acc(1'b1, sat_pkg::OFS_CYLLO, c & 32'hff);
      acc(1'b1, sat_pkg::OFS_CYLHI, (c >> 8) & 32'hff);
      acc(1'b1, sat_pkg::OFS_DEVHEAD, dh);
      acc(1'b1, sat_pkg::OFS_SECCNT, sc);
      acc(1'b1, sat_pkg::OFS_CMD, {24'h000000, op});
   endtask : cmd

   task automatic cmd_lba(input logic [7:0] op, input logic [31:0] b);
      cmd(op, b, b >> 8, lb | ((b >> 24) & 32'hf), 32'h0);
   endtask : cmd_lba

   task automatic geom_chk();
      rchk(sat_pkg::OFS_CURCYL, cc, "cur_cyl");
      rchk(sat_pkg::OFS_CURHEADS, ch, "cur_heads");
      rchk(sat_pkg::OFS_CURSPT, cs, "cur_spt");
      rchk(sat_pkg::OFS_CURCAP, cc * ch * cs, "cur_cap");
      rchk(sat_pkg::OFS_TOTAL, tot, "total");
   endtask : geom_chk

   task automatic chk_cmd(input logic [31:0] er, input logic mode, input logic [31:0] blk);
      rchk(sat_pkg::OFS_ERROR, er, "error");
      acc(1'b0, sat_pkg::OFS_STATUS, 32'h0);
      chk("status_err", 32'(er != 0), 32'(rd[sat_pkg::ST_ERR_BIT]));
      if (er == 0) begin
         chk("status_mode", 32'(mode), 32'(rd[sat_pkg::ST_MODE_BIT]));
         rchk(sat_pkg::OFS_RESULT, blk, "result");
      end
   endtask : chk_cmd

   task automatic chs_acc(input logic [31:0] c, h, s);
      logic [31:0] er;
      er = (c >= cc || h >= ch || s == 0 || s > cs) ? nf : 32'h0;
      cmd(sat_pkg::CMD_ACCESS, s, c, h, 32'h0);
      chk_cmd(er, 1'b0, (c * ch + h) * cs + s - 1);
   endtask : chs_acc

   task automatic lba_acc(input logic [31:0] b);
      cmd_lba(sat_pkg::CMD_ACCESS, b);
      chk_cmd((b >= tot) ? nf : 32'h0, 1'b1, b);
   endtask : lba_acc

   task automatic init_geom(input logic [31:0] h, s);
      logic [31:0] q;
      int n;
      q = 32'h0;
      if (s != 0) q = ((tot < 32'(sat_pkg::GEOM_MAX)) ? tot : 32'(sat_pkg::GEOM_MAX)) / (h * s);
      if (q > 32'hffff) q = 32'hffff;
      cmd(sat_pkg::CMD_INIT, 32'h0, 32'h0, h - 1, s);
      for (n = 0; n < 64; n++) begin
         acc(1'b0, sat_pkg::OFS_STATUS, 32'h0);
         if (rd[sat_pkg::ST_BUSY_BIT] === 1'b0) break;
      end
      if (n == 64) begin
         error_cnt++;
         summarize();
      end
      if (q != 0) begin
         cc = q;
         ch = h;
         cs = s;
      end
      rchk(sat_pkg::OFS_ERROR, (q == 0) ? ab : 32'h0, "init_error");
      geom_chk();
   endtask : init_geom

   task automatic set_max(input logic [31:0] t);
      logic ok;
      ok = t <= 32'(sat_pkg::NATIVE_TOTAL) && t >= cc * ch * cs;
      cmd_lba(sat_pkg::CMD_SETMAX, t - 1);
      if (ok) tot = t;
      rchk(sat_pkg::OFS_ERROR, ok ? 32'h0 : ab, "setmax_error");
      geom_chk();
   endtask : set_max

   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      cc = 32'(sat_pkg::DEF_CYL);
      ch = 32'(sat_pkg::DEF_HEADS);
      cs = 32'(sat_pkg::DEF_SPT);
      tot = 32'(sat_pkg::NATIVE_TOTAL);
   endtask : do_reset

   initial begin
      do_reset();
      rchk(sat_pkg::OFS_DEFCYL, 32'd16383, "def_cyl");
      rchk(sat_pkg::OFS_DEFHEADS, 32'd16, "def_heads");
      rchk(sat_pkg::OFS_DEFSPT, 32'd63, "def_spt");
      geom_chk();
      rchk(8'h44, 32'h0, "unmapped");
      chs_acc(0, 0, 1);
      chs_acc(cc - 1, 15, cs);
      chs_acc(cc, 0, 1);
      chs_acc(0, 0, 0);
      chs_acc(0, 0, cs + 1);
      lba_acc(tot - 1);
      lba_acc(tot);
      cmd(8'h7e, 32'h0, 32'h0, 32'h0, 32'h0);
      rchk(sat_pkg::OFS_ERROR, ab, "bad_opcode");
      init_geom(15, 255);
      chs_acc(0, 15, 1);
      init_geom(16, 0);
      init_geom(4, 17);
      set_max(5000000);
      lba_acc(4999999);
      lba_acc(5000000);
      set_max(100);
      set_max(32'(sat_pkg::NATIVE_TOTAL) + 1);
      init_geom(16, 255);
      for (int i = 0; i < 10; i++) begin
         init_geom(rnd() % 16 + 1, rnd() % 255 + 1);
         for (int j = 0; j < 5; j++) begin
            chs_acc(rnd() % (cc + 1), rnd() % 16, rnd() % (cs + 2));
            lba_acc(rnd() % (tot + tot / 8));
         end
      end
      do_reset();
      geom_chk();
      summarize();
   end
endmodule : test_sector_address_translation_check
